// >>> design/sps_map.vh
// Register indices, field positions, codes and timing counts of the serial port
`ifndef SPS_MAP_VH
`define SPS_MAP_VH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define SPS_IDX_BUFFER    10'h013
`define SPS_IDX_CONTROL   10'h014
`define SPS_IDX_STATE     10'h094

// ****************************************
// Field positions
// ****************************************
`define SPS_CTL_COLL      7
`define SPS_CTL_OVFL      6
`define SPS_CTL_ENABLE    5
`define SPS_CTL_POL       4
`define SPS_ST_SMP        7
`define SPS_ST_EDGE       6
`define SPS_ST_FULL       0

// ****************************************
// Reset values
// ****************************************
`define SPS_CONTROL_RST   8'h00
`define SPS_STATE_RST     8'h00

// ****************************************
// Mode field codes
// ****************************************
`define SPS_MODE_DIV4     4'h0
`define SPS_MODE_DIV16    4'h1
`define SPS_MODE_DIV64    4'h2
`define SPS_MODE_TIMER    4'h3
`define SPS_MODE_SLV_SEL  4'h4
`define SPS_MODE_SLV_FREE 4'h5
`define SPS_MODE_I2C7     4'h6
`define SPS_MODE_I2C10    4'h7
`define SPS_MODE_I2C7_SP  4'hb
`define SPS_MODE_I2C10_SP 4'hf

// ****************************************
// Timing counts: oscillator cycles per serial clock period
// ****************************************
`define SPS_DIV_A         7'd4
`define SPS_DIV_B         7'd16
`define SPS_DIV_C         7'd64

// ****************************************
// Bus answers
// ****************************************
`define SPS_RESP_OKAY     2'h0
`define SPS_RESP_SLVERR   2'h2

`endif

// >>> design/sps_pair_fifo.v
// Small valid/ready buffer for received bytes
`timescale 1ns/1ps
`default_nettype none

module sps_pair_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire             clock_in,
  input  wire             rst_in,
  input  wire             flush_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // Honest full and empty from the fill count
  assign in_ready_out  = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign out_data_out  = mem_q[rd_ptr_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Pointers and count
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

  // Storage, no reset needed on data
  always @(posedge clock_in) begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_in;
  end

endmodule // sps_pair_fifo

`default_nettype wire

// >>> design/sps_spi_port.v
// SPI master/slave serial port with mode select, enable and AXI4-Lite registers
//
// What this block does
// - Modes 0000, 0001, 0010 make a master whose clock is the oscillator over 4, 16 or 64.
// - Mode 0011 makes a master whose clock is half the rate of the timer two output.
// - Mode 0100 makes a slave on the clock pin, gated and framed by slave select.
// - Mode 0101 makes a slave on the clock pin that ignores slave select, freeing that pin.
// - Modes 0110, 0111, 1011, 1111 hand the port over to I2C slave operation instead of SPI.
// - The port stays inactive until the enable bit, control bit 5, is set.
// - In modes 0000 to 0101, setting enable gives the data-in, data-out and clock pins to the port, and the select pin only in mode 0100.
// - As a slave with select control, the SPI logic resets while select is high.
// - Clearing enable disables the port and returns its pins to ordinary I/O.
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.vh"

module sps_spi_port (
  input  wire        clock_in,
  input  wire        rst_in,
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Timer two output, one-cycle pulse
  input  wire        timer_two_tick_in,
  // Serial pins
  input  wire        serial_clk_in,
  output reg         serial_clk_out,
  output reg         serial_clk_oe_out,
  input  wire        serial_in_pin_in,
  output reg         serial_out_pin_out,
  output reg         serial_out_pin_oe_out,
  input  wire        slave_sel_n_in,
  // Pin ownership: 1 = serial function, 0 = general I/O
  output reg         pins_spi_out,
  output reg         slave_sel_spi_out,
  output reg         pins_i2c_out
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam S_IDLE  = 3'b001;
  localparam S_SHIFT = 3'b010;
  localparam S_DONE  = 3'b100;
  localparam [7:0] ST_RST = `SPS_STATE_RST;  // Status reset value as a sized word

  reg  [7:0] ctrl_q;
  reg  [1:0] cfg_q;            // Sample and edge select bits
  reg        full_q;
  reg  [7:0] rx_buf_q;
  reg  [7:0] tx_q;
  reg        tx_pend_q;
  reg  [7:0] shift_q;
  reg        in_bit_q;
  reg  [2:0] bit_cnt_q;
  reg  [2:0] state_q;
  reg  [5:0] div_cnt_q;
  reg        sck_q;
  reg        sck_prev_q;
  reg        aw_held_q;
  reg        w_held_q;
  reg  [9:0] aw_idx_q;
  reg  [7:0] wdat_q;
  reg        wlane_q;

  wire [3:0] mode     = ctrl_q[3:0];
  wire       enabled  = ctrl_q[`SPS_CTL_ENABLE];
  wire       pol      = ctrl_q[`SPS_CTL_POL];
  wire       is_mst   = enabled && (mode <= `SPS_MODE_TIMER);
  wire       is_slv   = enabled && (mode == `SPS_MODE_SLV_SEL ||
                                    mode == `SPS_MODE_SLV_FREE);
  wire       spi_on   = is_mst | is_slv;
  wire       sel_hold = is_slv && (mode == `SPS_MODE_SLV_SEL) && slave_sel_n_in;
  wire       do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire       rd_go    = s_axi_arvalid & s_axi_arready;
  wire       buf_wr   = do_write && wlane_q && (aw_idx_q == `SPS_IDX_BUFFER);
  wire       ctl_wr   = do_write && wlane_q && (aw_idx_q == `SPS_IDX_CONTROL);
  wire       st_wr    = do_write && wlane_q && (aw_idx_q == `SPS_IDX_STATE);
  wire       buf_rd   = rd_go && (s_axi_araddr[11:2] == `SPS_IDX_BUFFER);
  wire       busy     = (state_q != S_IDLE);

  // Half period of the divided clock for each master code
  function [5:0] half_count;
    input [3:0] m;
    reg   [6:0] full;
    begin
      case (m)
        `SPS_MODE_DIV4:  full = `SPS_DIV_A;
        `SPS_MODE_DIV16: full = `SPS_DIV_B;
        default:         full = `SPS_DIV_C;
      endcase
      half_count = full[6:1];
    end
  endfunction

  // Address decode shared by reads and writes
  function is_mapped;
    input [9:0] idx;
    begin
      is_mapped = (idx == `SPS_IDX_BUFFER) || (idx == `SPS_IDX_CONTROL) ||
                  (idx == `SPS_IDX_STATE);
    end
  endfunction

  // ****************************************
  // Serial clock edges
  // ****************************************
  wire       div_hit  = (div_cnt_q == half_count(mode) - 6'd1);
  wire       mst_tick = is_mst && (state_q == S_SHIFT) &&
                        ((mode == `SPS_MODE_TIMER) ? timer_two_tick_in : div_hit);
  wire       slv_edge = is_slv && !sel_hold && (serial_clk_in != sck_prev_q);
  wire       lead     = is_mst ? (mst_tick && sck_q == pol)
                               : (slv_edge && sck_prev_q == pol);
  wire       trail    = is_mst ? (mst_tick && sck_q != pol)
                               : (slv_edge && sck_prev_q != pol);

  // Receive buffer between shifter and buffer register
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       push_req = (state_q == S_DONE);

  sps_pair_fifo #(
    .WIDTH (8),
    .DEPTH (2),
    .AW    (1)
  ) u_rx_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .flush_in      (~spi_on),
    .in_valid_in   (push_req),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (shift_q),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (~full_q),
    .out_data_out  (fifo_out_data)
  );

  // ****************************************
  // Shifter and transfer sequencing
  // ****************************************
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= S_IDLE;
      shift_q    <= 8'h00;
      in_bit_q   <= 1'b0;
      bit_cnt_q  <= 3'h0;
      div_cnt_q  <= 6'h00;
      sck_q      <= 1'b0;
      sck_prev_q <= 1'b0;
      tx_pend_q  <= 1'b0;
    end else begin
      sck_prev_q <= serial_clk_in;
      if (!spi_on || sel_hold) begin
        // Disabled or deselected: shifter back to idle
        state_q   <= S_IDLE;
        bit_cnt_q <= 3'h0;
        div_cnt_q <= 6'h00;
        sck_q     <= pol;
        tx_pend_q <= spi_on & (tx_pend_q | (buf_wr & ~busy)); // Byte waits for select
      end else begin
        div_cnt_q <= (div_hit || state_q != S_SHIFT) ? 6'h00 : div_cnt_q + 6'd1;
        if (buf_wr && !busy)
          tx_pend_q <= 1'b1;
        case (state_q)
          S_IDLE: begin
            sck_q <= pol;
            if (tx_pend_q) begin
              shift_q   <= tx_q;
              tx_pend_q <= 1'b0;
              state_q   <= S_SHIFT;
            end else if (is_slv && lead) begin
              // Slave clocked without a new byte: shift out the last byte received
              in_bit_q <= serial_in_pin_in;
              state_q  <= S_SHIFT;
            end
          end
          S_SHIFT: begin
            if (mst_tick)
              sck_q <= ~sck_q;
            if (lead)
              in_bit_q <= serial_in_pin_in;
            if (trail) begin
              shift_q   <= {shift_q[6:0], in_bit_q};
              bit_cnt_q <= bit_cnt_q + 3'd1;
              if (bit_cnt_q == 3'd7)
                state_q <= S_DONE;
            end
          end
          S_DONE: begin
            // Master waits for room; a slave cannot wait and drops
            if (fifo_in_ready || is_slv)
              state_q <= S_IDLE;
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Registers: control, state, buffer
  // ****************************************
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q   <= `SPS_CONTROL_RST;
      cfg_q    <= ST_RST[7:6];
      full_q   <= 1'b0;
      rx_buf_q <= 8'h00;
      tx_q     <= 8'h00;
    end else begin
      if (ctl_wr)
        ctrl_q <= wdat_q;
      if (st_wr)
        cfg_q <= wdat_q[`SPS_ST_SMP:`SPS_ST_EDGE];
      if (buf_wr && !busy)
        tx_q <= wdat_q;
      // Collision: buffer written mid-transfer; set beats software clear
      if (buf_wr && busy)
        ctrl_q[`SPS_CTL_COLL] <= 1'b1;
      // Overflow: slave byte with no room; set beats software clear
      if (push_req && is_slv && !fifo_in_ready)
        ctrl_q[`SPS_CTL_OVFL] <= 1'b1;
      // Buffer full flag: set on load, cleared by reading the buffer
      if (fifo_out_valid && !full_q) begin
        rx_buf_q <= fifo_out_data;
        full_q   <= 1'b1;
      end else if (buf_rd) begin
        full_q <= 1'b0;
      end
      if (!spi_on)
        full_q <= full_q & ~buf_rd;
    end
  end

  // ****************************************
  // Pin ownership and drivers
  // ****************************************
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pins_spi_out          <= 1'b0;
      slave_sel_spi_out     <= 1'b0;
      pins_i2c_out          <= 1'b0;
      serial_clk_out        <= 1'b0;
      serial_clk_oe_out     <= 1'b0;
      serial_out_pin_out    <= 1'b0;
      serial_out_pin_oe_out <= 1'b0;
    end else begin
      pins_spi_out      <= spi_on;
      slave_sel_spi_out <= is_slv && (mode == `SPS_MODE_SLV_SEL);
      pins_i2c_out      <= enabled && (mode == `SPS_MODE_I2C7 ||
                                       mode == `SPS_MODE_I2C10 ||
                                       mode == `SPS_MODE_I2C7_SP ||
                                       mode == `SPS_MODE_I2C10_SP);
      serial_clk_out        <= sck_q;
      serial_clk_oe_out     <= is_mst;
      serial_out_pin_out    <= shift_q[7];
      serial_out_pin_oe_out <= is_mst || (is_slv && !sel_hold);
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_idx_q      <= 10'h000;
      wdat_q        <= 8'h00;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPS_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdat_q   <= s_axi_wdata[7:0];
        wlane_q  <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_idx_q) ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SPS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= is_mapped(s_axi_araddr[11:2]) ? `SPS_RESP_OKAY
                                                        : `SPS_RESP_SLVERR;
        case (s_axi_araddr[11:2])
          `SPS_IDX_BUFFER:  s_axi_rdata <= {24'h000000, rx_buf_q};
          `SPS_IDX_CONTROL: s_axi_rdata <= {24'h000000, ctrl_q};
          `SPS_IDX_STATE:   s_axi_rdata <= {24'h000000, cfg_q, 5'h00, full_q};
          default:          s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sps_spi_port

`default_nettype wire

// >>> bench/sps_spi_chk.sv
// Port-level assertions for the serial port block
`timescale 1ns/1ps
`default_nettype none
module sps_spi_chk (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_clk_oe_out,
  input wire logic        serial_out_pin_oe_out,
  input wire logic        slave_sel_n_in,
  input wire logic        pins_spi_out,
  input wire logic        slave_sel_spi_out,
  input wire logic        pins_i2c_out
);
  // ****************************************
  // Bus handshakes and pin ownership
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence wr_offer; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
  sequence rd_offer; s_axi_arvalid && !s_axi_rvalid; endsequence
  sequence sel_off; slave_sel_spi_out && slave_sel_n_in; endsequence
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  write_answer_a: assert property (wr_offer |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (rd_offer |-> ##[1:3] s_axi_rvalid)
    else $error("read answer late");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  pin_owner_a: assert property (!(pins_spi_out && pins_i2c_out))
    else $error("pins owned twice");
  clk_drive_a: assert property ($past(serial_clk_oe_out) && serial_clk_oe_out |->
    pins_spi_out && !slave_sel_spi_out) else $error("clock driven outside master");
  sel_owner_a: assert property ($past(slave_sel_spi_out) && slave_sel_spi_out |->
    pins_spi_out && !serial_clk_oe_out) else $error("select used outside slave");
  sel_gate_a: assert property (sel_off [*2] |-> !serial_out_pin_oe_out)
    else $error("data driven while deselected");
  idle_pins_a: assert property (!pins_spi_out && !$past(pins_spi_out) |->
    !serial_out_pin_oe_out && !serial_clk_oe_out) else $error("pins driven while off");
endmodule // sps_spi_chk
bind sps_spi_port sps_spi_chk sps_spi_chk_inst (.clock_in, .rst_in, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .serial_clk_oe_out, .serial_out_pin_oe_out, .slave_sel_n_in,
  .pins_spi_out, .slave_sel_spi_out, .pins_i2c_out);
`default_nettype wire

// >>> bench/sps_peer.sv
// Behavioural far-side device: slave to a master port, master to a slave port
`timescale 1ns/1ps
`default_nettype none
module sps_peer #(
  parameter HALF = 3
) (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       master_in,
  input  wire logic       go_in,
  input  wire logic [7:0] tx_in,
  input  wire logic       dut_clk_in,
  input  wire logic       dut_data_in,
  output logic            clk_out,
  output logic            data_out,
  output logic            sel_n_out,
  output logic [7:0]      rx_out,
  output logic            done_out
);
  // ****************************************
  // Frame engine
  // ****************************************
  logic [7:0] tx_q;
  logic [3:0] bits_q;
  logic [3:0] cnt_q;
  logic       prev_q;
  logic       busy_q;
  logic       flip_q;
  wire        sck = master_in ? clk_out : dut_clk_in;
  // Select low only in own frames; data line churns when released
  assign sel_n_out = !(master_in && busy_q);
  // Next bit shows as soon as the clock falls, ahead of the shift
  assign data_out  = busy_q ? ((!sck && prev_q) ? tx_q[6] : tx_q[7]) : flip_q;
  // Edge detection, shifting and frame count
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      {tx_q, rx_out, bits_q, cnt_q} <= '0;
      {prev_q, busy_q, flip_q, clk_out, done_out} <= '0;
    end else begin
      prev_q   <= sck;
      flip_q   <= ~flip_q;
      done_out <= 1'b0;
      if (go_in) begin
        tx_q   <= tx_in;
        bits_q <= 4'h0;
        cnt_q  <= 4'h0;
        busy_q <= 1'b1;
      end
      // Clock runs only inside a frame, idle low
      if (master_in && busy_q) begin
        cnt_q <= (cnt_q == HALF) ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q == HALF) clk_out <= ~clk_out;
      end
      // Sample on leading edge, msb first
      if (busy_q && sck && !prev_q) begin
        rx_out <= {rx_out[6:0], dut_data_in};
        bits_q <= bits_q + 4'h1;
      end
      // Shift on trailing edge; eighth one ends the frame
      if (busy_q && !sck && prev_q) begin
        tx_q <= {tx_q[6:0], 1'b0};
        if (bits_q == 4'h8) begin
          busy_q   <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // sps_peer
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench: register bus, master and slave transfers, pin hand-over
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.vh"
module tb_top;
  // ****************************************
  // Signals, design and far side
  // ****************************************
  localparam logic [11:0] A_BUF = {`SPS_IDX_BUFFER, 2'b00};
  localparam logic [11:0] A_CTL = {`SPS_IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_ST  = {`SPS_IDX_STATE, 2'b00};
  logic        clock_in = 0, rst_in = 1, timer_two_tick_in = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        serial_clk_out, serial_clk_oe_out, serial_out_pin_out, serial_out_pin_oe_out;
  logic        pins_spi_out, slave_sel_spi_out, pins_i2c_out;
  wire         serial_clk_in, serial_in_pin_in, slave_sel_n_in, p_sel, p_done;
  wire  [7:0]  p_rx;
  logic        p_mst = 0, p_go = 0, sel_blk = 0, rx_on = 0, sck_prev = 0;
  logic [7:0]  p_tx = 0;
  logic [33:0] exp_q[$];
  logic [7:0]  rxe_q[$];
  int          err_total = 0, checks = 0, cyc = 0, last = 0, per = 0;
  sps_spi_port sps_spi_port_inst (.*);
  sps_peer #(.HALF(3)) sps_peer_inst (.clock_in(clock_in), .rst_in(rst_in), .master_in(p_mst),
    .go_in(p_go), .tx_in(p_tx), .dut_clk_in(serial_clk_out),
    .dut_data_in(serial_out_pin_oe_out ? serial_out_pin_out : ~serial_out_pin_out),
    .clk_out(serial_clk_in), .data_out(serial_in_pin_in), .sel_n_out(p_sel),
    .rx_out(p_rx), .done_out(p_done));
  assign slave_sel_n_in = p_sel | sel_blk;
  always #4 clock_in = ~clock_in;
  // Timer tick every third cycle, clock period meter, scoreboard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    timer_two_tick_in <= (cyc % 3 == 0);
    sck_prev <= serial_clk_out;
    if (serial_clk_out && !sck_prev) begin
      per  <= cyc - last;
      last <= cyc;
    end
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (p_done && rx_on) chk(p_rx, rxe_q.pop_front());
  end
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One bus transfer; expected answer noted first
  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
    int n;
    exp_q.push_back({r, w ? 32'h0 : d});
    @(posedge clock_in);
    if (w) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
    end
    for (n = 0; n < 60; n++) begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    if (n == 60) begin
      err_total++;
      close_out;
    end
    if (w) repeat (2) @(posedge clock_in);
  endtask
  task automatic go(input logic [7:0] b);
    @(posedge clock_in);
    p_tx <= b;
    p_go <= 1'b1;
    @(posedge clock_in);
    p_go <= 1'b0;
  endtask
  // Mode written with enable off, then enable set
  task automatic setup(input logic [7:0] c);
    xfer(1, A_CTL, {24'h0, c & 8'hdf}, `SPS_RESP_OKAY);
    xfer(1, A_CTL, {24'h0, c}, `SPS_RESP_OKAY);
  endtask
  // One byte each way; the clocking side starts last
  task automatic frame(input logic [7:0] pb, input logic [7:0] db);
    int n;
    if (rx_on) rxe_q.push_back(db);
    if (!p_mst) go(pb);
    xfer(1, A_BUF, {24'h0, db}, `SPS_RESP_OKAY);
    if (p_mst) go(pb);
    for (n = 0; n < 2000 && !p_done; n++) @(posedge clock_in);
    if (n == 2000) begin
      err_total++;
      close_out;
    end
    repeat (8) @(posedge clock_in);
  endtask
  initial begin
    logic [7:0] pb;
    logic [7:0] db;
    int         m;
    void'($urandom(5006));
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    // Reset values, unmapped places, enable still off
    xfer(0, A_CTL, {24'h0, `SPS_CONTROL_RST}, `SPS_RESP_OKAY);
    xfer(0, A_ST, {24'h0, `SPS_STATE_RST}, `SPS_RESP_OKAY);
    xfer(0, 12'h000, 32'h0, `SPS_RESP_SLVERR);
    xfer(1, 12'h004, 32'h0, `SPS_RESP_SLVERR);
    xfer(1, A_CTL, 32'h0, `SPS_RESP_OKAY);
    chk(pins_spi_out, 1'b0);
    // Master from every clock source
    rx_on <= 1'b1;
    for (m = 0; m < 4; m++) begin
      pb = $urandom;
      db = $urandom;
      setup({4'h2, m[3:0]});
      chk({pins_spi_out, serial_clk_oe_out}, 2'b11);
      frame(pb, db);
      chk(per, m == 3 ? 6 : 4 << (2 * m));
      xfer(0, A_ST, 32'h1, `SPS_RESP_OKAY);
      xfer(0, A_BUF, pb, `SPS_RESP_OKAY);
      xfer(1, A_CTL, 32'h0, `SPS_RESP_OKAY);
      chk(pins_spi_out, 1'b0);
    end
    // Slave: select framing, select held off, select ignored
    p_mst <= 1'b1;
    for (m = 0; m < 3; m++) begin
      pb = $urandom;
      db = $urandom;
      sel_blk <= (m != 0);
      rx_on <= (m != 1);
      setup(m == 2 ? 8'h25 : 8'h24);
      xfer(1, A_ST, m == 0 ? 32'h40 : 32'h0, `SPS_RESP_OKAY);
      chk({slave_sel_spi_out, serial_clk_oe_out}, {m != 2, 1'b0});
      frame(pb, db);
      xfer(0, A_ST, (m == 0 ? 32'h40 : 32'h0) | (m != 1), `SPS_RESP_OKAY);
      if (m != 1) xfer(0, A_BUF, pb, `SPS_RESP_OKAY);
      xfer(1, A_CTL, 32'h0, `SPS_RESP_OKAY);
    end
    // Codes that hand the pins to the two-wire function
    for (m = 0; m < 4; m++) begin
      setup({4'h2, m == 2 ? `SPS_MODE_I2C7_SP : m == 3 ? `SPS_MODE_I2C10_SP
                                              : `SPS_MODE_I2C7 + m[3:0]});
      chk({pins_i2c_out, pins_spi_out}, 2'b10);
      xfer(1, A_CTL, 32'h0, `SPS_RESP_OKAY);
    end
    close_out;
  end
endmodule // tb_top
`default_nettype wire
